// ### rtl/dnsd_device.sv
// Notes on behaviour
// - 16-bit offset left-justified, added to accumulator
// - Offset full range equals one cycle
// - Controller resyncs NCOs after frequency changes
// - Sync via SYNC or SYSREF per bits
// - SYNC sync still works in 64b/66b
// - Init bit set, link off, SYNC high
// - SYNC low with link: CGS or arm
// - SYNC deassertion synchronizes all NCOs together
// - DC SYSREF: hold low, then arm
// - Armed device syncs on one SYSREF pulse
// - Continuous SYSREF: arm between two edges
// - Sync on first SYSREF edge after arming
// - Filters complex, 15-bit results
// - Linear-phase FIR, symmetric coefficients
// - Bypass outputs real 12-bit at clock rate
// - Complex output at clock over 4..32
// - Stage cascade order per decimation factor
// - Output word: 15 data bits, over-range bit
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns
`include "dnsd_defs.svh"
module dnsd_device
  import dnsd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  dnsd_link_if.device link,
  input wire logic [11:0] adc_sample,
  input wire dnsd_sample_t mixer_i,
  input wire dnsd_sample_t mixer_q,
  input wire logic mixer_valid,
  input wire logic overrange_flag_zero,
  input wire logic overrange_flag_one,
  input wire logic [1:0] nco_sel_a,
  input wire logic [1:0] nco_sel_b,
  output logic [31:0] nco_phase_a,
  output logic [31:0] nco_phase_b,
  output logic [15:0] out_i_word,
  output logic [15:0] out_q_word,
  output logic [11:0] out_real,
  output logic out_valid,
  output logic out_complex
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for SYNC and SYSREF.
  logic sync_meta;
  logic sync_s;
  logic sync_d;
  logic sysref_meta;
  logic sysref_s;
  logic sysref_d;
  logic arm_d;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync_meta <= 1'b1;
      sync_s <= 1'b1;
      sync_d <= 1'b1;
      sysref_meta <= 1'b0;
      sysref_s <= 1'b0;
      sysref_d <= 1'b0;
      arm_d <= 1'b0;
    end else if (ce) begin
      sync_meta <= link.link_sync;
      sync_s <= sync_meta;
      sync_d <= sync_s;
      sysref_meta <= link.sysref;
      sysref_s <= sysref_meta;
      sysref_d <= sysref_s;
      arm_d <= link.sync_on_next_sysref;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisation state machine.
  dnsd_sync_state_t state;
  dnsd_sync_state_t next_state;
  logic synced;
  logic next_synced;

  always_comb begin
    next_state = state;
    next_synced = 1'b0;
    case (state)
      DNSD_IDLE: begin
        if (link.sync_on_link_init && link.link_enable && !sync_s) begin
          next_state = DNSD_LINK_ARMED;
        end else if (link.sync_on_next_sysref && !arm_d) begin
          next_state = DNSD_SYSREF_ARMED;
        end
      end
      DNSD_LINK_ARMED: begin
        if (!link.link_enable || !link.sync_on_link_init) begin
          next_state = DNSD_IDLE;
        end else if (sync_s && !sync_d) begin
          next_state = DNSD_IDLE;
          next_synced = 1'b1;
        end
      end
      DNSD_SYSREF_ARMED: begin
        if (!link.sync_on_next_sysref) begin
          next_state = DNSD_IDLE;
        end else if (sysref_s && !sysref_d) begin
          next_state = DNSD_IDLE;
          next_synced = 1'b1;
        end
      end
      default: next_state = DNSD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= DNSD_IDLE;
      synced <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      synced <= next_synced;
    end
  end

  assign link.cgs_active = (state == DNSD_LINK_ARMED) && !link.link_64b66b;
  assign link.nco_synced = synced;

  ////////////////////////////////////////////////////////////////////////////
  // Eight phase accumulators, four per channel, all running continuously.
  logic [7:0][31:0] acc;
  logic [7:0][31:0] next_acc;
  logic [7:0][31:0] phase;
  logic [31:0] next_phase_a;
  logic [31:0] next_phase_b;

  for (genvar n = 0; n < 8; n++) begin : g_nco
    logic [31:0] word;
    logic [15:0] offset;
    assign word = (n < 4) ? link.chan_a_tuning_word[n % 4] : link.chan_b_tuning_word[n % 4];
    assign offset = (n < 4) ? link.chan_a_phase_offset[n % 4] : link.chan_b_phase_offset[n % 4];
    // Clearing all accumulators on one cycle gives every device the same phase.
    always_comb begin
      next_acc[n] = synced ? 32'h00000000 : acc[n] + word;
    end
    assign phase[n] = acc[n] + {offset, 16'h0000};
  end

  always_comb begin
    next_phase_a = phase[{1'b0, nco_sel_a}];
    next_phase_b = phase[{1'b1, nco_sel_b}];
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      acc <= '0;
      nco_phase_a <= 32'h00000000;
      nco_phase_b <= 32'h00000000;
    end else if (ce) begin
      acc <= next_acc;
      nco_phase_a <= next_phase_a;
      nco_phase_b <= next_phase_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decimation chain. Stages ahead of the first active one sit idle.
  logic [2:0] first_stage;
  logic [4:0] st_in_valid;
  logic [4:0] st_out_valid;
  dnsd_sample_t st_in_i [5];
  dnsd_sample_t st_in_q [5];
  dnsd_sample_t st_out_i [5];
  dnsd_sample_t st_out_q [5];
  logic bypass;

  assign bypass = (link.decim_sel == DNSD_BYPASS) || (link.decim_sel > DNSD_DEC32);
  assign first_stage = bypass ? 3'h5 : 3'(3'h5 - link.decim_sel - 3'h1);

  for (genvar k = 0; k < 5; k++) begin : g_stage
    if (k == 0) begin : g_head
      assign st_in_valid[k] = mixer_valid && (first_stage == 3'h0);
      assign st_in_i[k] = mixer_i;
      assign st_in_q[k] = mixer_q;
    end else begin : g_tail
      assign st_in_valid[k] = (first_stage == 3'(k)) ? mixer_valid :
                              (first_stage < 3'(k)) ? st_out_valid[k-1] : 1'b0;
      assign st_in_i[k] = (first_stage == 3'(k)) ? mixer_i : st_out_i[k-1];
      assign st_in_q[k] = (first_stage == 3'(k)) ? mixer_q : st_out_q[k-1];
    end
    dnsd_halfband u_stage (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ce(ce),
      .in_valid(st_in_valid[k]),
      .in_i(st_in_i[k]),
      .in_q(st_in_q[k]),
      .out_valid(st_out_valid[k]),
      .out_i(st_out_i[k]),
      .out_q(st_out_q[k])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output formatting.
  logic [15:0] next_i_word;
  logic [15:0] next_q_word;
  logic [11:0] next_real;
  logic next_valid;
  logic next_complex;

  always_comb begin
    next_i_word = out_i_word;
    next_q_word = out_q_word;
    next_real = out_real;
    next_valid = 1'b0;
    next_complex = !bypass;
    if (bypass) begin
      next_real = adc_sample;
      next_valid = 1'b1;
    end else if (st_out_valid[4]) begin
      next_i_word = {st_out_i[4], overrange_flag_zero};
      next_q_word = {st_out_q[4], overrange_flag_one};
      next_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      out_i_word <= 16'h0000;
      out_q_word <= 16'h0000;
      out_real <= 12'h000;
      out_valid <= 1'b0;
      out_complex <= 1'b0;
    end else if (ce) begin
      out_i_word <= next_i_word;
      out_q_word <= next_q_word;
      out_real <= next_real;
      out_valid <= next_valid;
      out_complex <= next_complex;
    end
  end

endmodule // dnsd_device

// ### include/dnsd_defs.svh
`ifndef DNSD_DEFS_SVH
`define DNSD_DEFS_SVH

// Host register byte offsets.
`define DNSD_REG_CTRL 8'h00
`define DNSD_REG_SYSREF 8'h04
`define DNSD_REG_STATUS 8'h08
`define DNSD_REG_PHASE_BASE 8'h20
`define DNSD_REG_FREQ_A_BASE 8'h40
`define DNSD_REG_FREQ_B_BASE 8'h60

// Control register fields.
`define DNSD_CTRL_SYNC_INIT 0
`define DNSD_CTRL_SYNC_NEXT 1
`define DNSD_CTRL_LINK_EN 2
`define DNSD_CTRL_ENC_64B 3
`define DNSD_CTRL_SYNC_LEVEL 4
`define DNSD_CTRL_SYSREF_RUN 5
`define DNSD_CTRL_DECIM_LSB 8
`define DNSD_CTRL_RESET 32'h00000010

// SYSREF register and status register fields.
`define DNSD_SYSREF_PULSE 0
`define DNSD_STAT_SYNC_LINE 0
`define DNSD_STAT_CGS 1
`define DNSD_STAT_SYNCED 2

// Continuous SYSREF period in device clock cycles.
`define DNSD_SYSREF_PERIOD 8'h10

// Half-band stage taps, symmetric about the centre tap, and output scale shift.
`define DNSD_HB_C0 (-24'sh000001)
`define DNSD_HB_C2 24'sh000009
`define DNSD_HB_C3 24'sh000010
`define DNSD_HB_SHIFT 5
`define DNSD_SAT_MAX 24'sh003FFF
`define DNSD_SAT_MIN (-24'sh004000)

`endif

// ### include/dnsd_pkg.sv
package dnsd_pkg;

  typedef enum logic [2:0] {
    DNSD_IDLE = 3'h1,
    DNSD_LINK_ARMED = 3'h2,
    DNSD_SYSREF_ARMED = 3'h4
  } dnsd_sync_state_t;

  typedef enum logic [2:0] {
    DNSD_BYPASS = 3'h0,
    DNSD_DEC4 = 3'h1,
    DNSD_DEC8 = 3'h2,
    DNSD_DEC16 = 3'h3,
    DNSD_DEC32 = 3'h4
  } dnsd_decim_t;

  typedef logic signed [14:0] dnsd_sample_t;

endpackage

// ### include/dnsd_link_if.sv
`timescale 1ns/1ns
interface dnsd_link_if;
  import dnsd_pkg::*;
  logic link_sync;
  logic sysref;
  logic sync_on_link_init;
  logic sync_on_next_sysref;
  logic link_enable;
  logic link_64b66b;
  dnsd_decim_t decim_sel;
  logic [3:0][15:0] chan_a_phase_offset;
  logic [3:0][15:0] chan_b_phase_offset;
  logic [3:0][31:0] chan_a_tuning_word;
  logic [3:0][31:0] chan_b_tuning_word;
  logic cgs_active;
  logic nco_synced;

  modport host (
    output link_sync, sysref, sync_on_link_init, sync_on_next_sysref, link_enable,
    output link_64b66b, decim_sel, chan_a_phase_offset, chan_b_phase_offset,
    output chan_a_tuning_word, chan_b_tuning_word,
    input cgs_active, nco_synced
  );

  modport device (
    input link_sync, sysref, sync_on_link_init, sync_on_next_sysref, link_enable,
    input link_64b66b, decim_sel, chan_a_phase_offset, chan_b_phase_offset,
    input chan_a_tuning_word, chan_b_tuning_word,
    output cgs_active, nco_synced
  );
endinterface

// ### rtl/dnsd_halfband.sv
`timescale 1ns/1ns
`include "dnsd_defs.svh"
module dnsd_halfband
  import dnsd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic in_valid,
  input wire dnsd_sample_t in_i,
  input wire dnsd_sample_t in_q,
  output logic out_valid,
  output dnsd_sample_t out_i,
  output dnsd_sample_t out_q
);

  dnsd_sample_t tap [2][7];
  dnsd_sample_t next_tap [2][7];
  dnsd_sample_t res [2];
  dnsd_sample_t next_res [2];
  logic odd;
  logic next_odd;
  logic next_out_valid;
  dnsd_sample_t lane_in [2];

  assign lane_in[0] = in_i;
  assign lane_in[1] = in_q;
  assign out_i = res[0];
  assign out_q = res[1];

  ////////////////////////////////////////////////////////////////////////////
  // symmetric FIR taps
  for (genvar l = 0; l < 2; l++) begin : g_lane
    logic signed [23:0] acc;
    logic signed [23:0] scaled;
    always_comb begin
      acc = `DNSD_HB_C0 * (24'(tap[l][0]) + 24'(tap[l][6]))
          + `DNSD_HB_C2 * (24'(tap[l][2]) + 24'(tap[l][4]))
          + `DNSD_HB_C3 * 24'(tap[l][3]);
      scaled = acc >>> `DNSD_HB_SHIFT;
      next_tap[l] = tap[l];
      next_res[l] = res[l];
      if (in_valid) begin
        for (int t = 6; t > 0; t--) begin
          next_tap[l][t] = tap[l][t-1];
        end
        next_tap[l][0] = lane_in[l];
      end
      // Saturation keeps a full-scale step from wrapping sign.
      if (in_valid && odd) begin
        if (scaled > `DNSD_SAT_MAX) begin
          next_res[l] = 15'h3FFF;
        end else if (scaled < `DNSD_SAT_MIN) begin
          next_res[l] = 15'h4000;
        end else begin
          next_res[l] = scaled[14:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decimate by two
  always_comb begin
    next_odd = odd;
    next_out_valid = 1'b0;
    if (in_valid) begin
      next_odd = ~odd;
      next_out_valid = odd;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      odd <= 1'b0;
      out_valid <= 1'b0;
      for (int l = 0; l < 2; l++) begin
        res[l] <= 15'h0000;
        for (int t = 0; t < 7; t++) begin
          tap[l][t] <= 15'h0000;
        end
      end
    end else if (ce) begin
      odd <= next_odd;
      out_valid <= next_out_valid;
      tap <= next_tap;
      res <= next_res;
    end
  end

endmodule // dnsd_halfband

// ### rtl/dnsd_host.sv
`timescale 1ns/1ns
`include "dnsd_defs.svh"
module dnsd_host
  import dnsd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  dnsd_link_if.host link
);

  logic [31:0] ctrl;
  logic [3:0][31:0] phase;
  logic [3:0][31:0] freq_a;
  logic [3:0][31:0] freq_b;
  logic sync_seen;
  logic sysref_out;
  logic [7:0] sysref_cnt;
  logic ack;
  logic [31:0] next_ctrl;
  logic [3:0][31:0] next_phase;
  logic [3:0][31:0] next_freq_a;
  logic [3:0][31:0] next_freq_b;
  logic next_sync_seen;
  logic next_sysref_out;
  logic [7:0] next_sysref_cnt;
  logic next_ack;
  logic [31:0] next_readdata;
  logic [31:0] wmask;
  logic wr_en;
  logic [1:0] idx;

  ////////////////////////////////////////////////////////////////////////////
  // One wait state: request seen, then acknowledged on the next edge.
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign wr_en = avs_write && ack;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign idx = avs_address[3:2];

  always_comb begin
    next_ack = (avs_read || avs_write) && !ack;
    next_ctrl = ctrl;
    next_phase = phase;
    next_freq_a = freq_a;
    next_freq_b = freq_b;
    next_readdata = avs_readdata;
    next_sysref_out = 1'b0;
    next_sysref_cnt = sysref_cnt;
    // A sync event in the clearing cycle survives the clear.
    next_sync_seen = link.nco_synced || sync_seen;
    if (avs_read && !ack) begin
      if (avs_address == `DNSD_REG_CTRL) begin
        next_readdata = ctrl;
      end else if (avs_address == `DNSD_REG_STATUS) begin
        next_readdata = {29'h00000000, sync_seen, link.cgs_active, ctrl[`DNSD_CTRL_SYNC_LEVEL]};
      end else if (avs_address[7:4] == 4'h2) begin
        next_readdata = phase[idx];
      end else if (avs_address[7:4] == 4'h4) begin
        next_readdata = freq_a[idx];
      end else if (avs_address[7:4] == 4'h6) begin
        next_readdata = freq_b[idx];
      end else begin
        next_readdata = 32'h00000000;
      end
    end
    if (wr_en) begin
      if (avs_address == `DNSD_REG_CTRL) begin
        next_ctrl = (ctrl & ~wmask) | (avs_writedata & wmask);
      end else if (avs_address == `DNSD_REG_SYSREF) begin
        next_sysref_out = avs_writedata[`DNSD_SYSREF_PULSE] && avs_byteenable[0];
      end else if (avs_address == `DNSD_REG_STATUS) begin
        if (avs_writedata[`DNSD_STAT_SYNCED] && avs_byteenable[0]) begin
          next_sync_seen = link.nco_synced;
        end
      end else if (avs_address[7:4] == 4'h2) begin
        next_phase[idx] = (phase[idx] & ~wmask) | (avs_writedata & wmask);
      end else if (avs_address[7:4] == 4'h4) begin
        next_freq_a[idx] = (freq_a[idx] & ~wmask) | (avs_writedata & wmask);
      end else if (avs_address[7:4] == 4'h6) begin
        next_freq_b[idx] = (freq_b[idx] & ~wmask) | (avs_writedata & wmask);
      end
    end
    if (ctrl[`DNSD_CTRL_SYSREF_RUN]) begin
      if (sysref_cnt == `DNSD_SYSREF_PERIOD - 8'h01) begin
        next_sysref_cnt = 8'h00;
        next_sysref_out = 1'b1;
      end else begin
        next_sysref_cnt = sysref_cnt + 8'h01;
      end
    end else begin
      next_sysref_cnt = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `DNSD_CTRL_RESET;
      phase <= '0;
      freq_a <= '0;
      freq_b <= '0;
      sync_seen <= 1'b0;
      sysref_out <= 1'b0;
      sysref_cnt <= 8'h00;
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else if (ce) begin
      ctrl <= next_ctrl;
      phase <= next_phase;
      freq_a <= next_freq_a;
      freq_b <= next_freq_b;
      sync_seen <= next_sync_seen;
      sysref_out <= next_sysref_out;
      sysref_cnt <= next_sysref_cnt;
      ack <= next_ack;
      avs_readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software sequences SYNC
  assign link.link_sync = ctrl[`DNSD_CTRL_SYNC_LEVEL];
  assign link.sysref = sysref_out;
  assign link.sync_on_link_init = ctrl[`DNSD_CTRL_SYNC_INIT];
  assign link.sync_on_next_sysref = ctrl[`DNSD_CTRL_SYNC_NEXT];
  assign link.link_enable = ctrl[`DNSD_CTRL_LINK_EN];
  assign link.link_64b66b = ctrl[`DNSD_CTRL_ENC_64B];
  assign link.decim_sel = dnsd_decim_t'(ctrl[`DNSD_CTRL_DECIM_LSB +: 3]);
  for (genvar n = 0; n < 4; n++) begin : g_word
    assign link.chan_a_phase_offset[n] = phase[n][15:0];
    assign link.chan_b_phase_offset[n] = phase[n][31:16];
    assign link.chan_a_tuning_word[n] = freq_a[n];
    assign link.chan_b_tuning_word[n] = freq_b[n];
  end

endmodule // dnsd_host

// ### verification/dnsd_props.sv
`timescale 1ns/1ns
module dnsd_props (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic link_sync,
  input wire logic sysref,
  input wire logic sync_on_link_init,
  input wire logic sync_on_next_sysref,
  input wire logic link_enable,
  input wire logic link_64b66b,
  input wire logic cgs_active,
  input wire logic nco_synced
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic fired;
  logic next_fired;

  // Once a sync has been taken the arm is spent, so later pulses must be ignored.
  always_comb next_fired = sync_on_next_sysref & (fired | nco_synced);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      fired <= 1'b0;
    else
      fired <= next_fired;
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_sync_lag;
    ##3 nco_synced;
  endsequence
  sequence s_cgs_lag;
    ##3 cgs_active;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_synced_one_cycle: assert property (
    nco_synced |=> !nco_synced) else $error("sync pulse too long");
  a_sync_has_cause: assert property (
    nco_synced |-> $past(sysref, 3) || ($past(link_sync, 3) && !$past(link_sync, 4)))
    else $error("sync without cause");
  a_armed_sysref_sync: assert property (
    sysref && sync_on_next_sysref && !fired |-> s_sync_lag)
    else $error("armed sysref missed");
  a_link_release_sync: assert property (
    $rose(link_sync) && cgs_active |-> s_sync_lag) else $error("release sync missed");
  a_cgs_start: assert property (
    $fell(link_sync) && link_enable && sync_on_link_init && !link_64b66b |-> s_cgs_lag)
    else $error("code group sync not started");
  a_cgs_mode_only: assert property (
    cgs_active |-> sync_on_link_init && link_enable && !link_64b66b)
    else $error("code group sync in wrong mode");
  a_sync_ends_cgs: assert property (
    nco_synced |-> !cgs_active) else $error("cgs still active at sync");
  a_sysref_pulse: assert property (
    sysref |=> !sysref) else $error("sysref pulse too long");
endmodule // dnsd_props

// ### verification/ddc_nco_sync_decimation_tb.sv
`timescale 1ns/1ns
module ddc_nco_sync_decimation_tb;
  import dnsd_pkg::*;
  logic sys_clk;
  logic rstn;
  logic ce;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] adc_sample;
  dnsd_sample_t mixer_i;
  dnsd_sample_t mixer_q;
  logic mixer_valid;
  logic overrange_flag_zero;
  logic overrange_flag_one;
  logic [1:0] nco_sel_a;
  logic [1:0] nco_sel_b;
  logic [31:0] nco_phase_a;
  logic [31:0] nco_phase_b;
  logic [15:0] out_i_word;
  logic [15:0] out_q_word;
  logic [11:0] out_real;
  logic out_valid;
  logic out_complex;
  logic [31:0] exp_q[$];
  logic [31:0] rng;
  logic [31:0] pa[4];
  logic [31:0] fa;
  logic [31:0] p0;
  logic [31:0] p1;
  logic [1:0] sync_hist;
  int miscompares;
  int n_tests;
  int n_sync;
  int n_valid;

  dnsd_link_if dnsd_link_if_i ();
  dnsd_host dnsd_host_i (.sys_clk, .rstn, .ce, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .link(dnsd_link_if_i));
  dnsd_device dnsd_device_i (.sys_clk, .rstn, .ce, .link(dnsd_link_if_i), .adc_sample,
    .mixer_i, .mixer_q, .mixer_valid, .overrange_flag_zero, .overrange_flag_one, .nco_sel_a,
    .nco_sel_b, .nco_phase_a, .nco_phase_b, .out_i_word, .out_q_word, .out_real, .out_valid,
    .out_complex);
  dnsd_props dnsd_props_i (.sys_clk, .rstn, .link_sync(dnsd_link_if_i.link_sync),
    .sysref(dnsd_link_if_i.sysref), .sync_on_link_init(dnsd_link_if_i.sync_on_link_init),
    .sync_on_next_sysref(dnsd_link_if_i.sync_on_next_sysref),
    .link_enable(dnsd_link_if_i.link_enable), .link_64b66b(dnsd_link_if_i.link_64b66b),
    .cgs_active(dnsd_link_if_i.cgs_active), .nco_synced(dnsd_link_if_i.nco_synced));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // The request is held until waitrequest has stood low across a rising edge.
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d, logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  task automatic idle(int n);
    repeat (n) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0)
      check("readdata", avs_readdata, exp_q.pop_front());
    if (rstn && dnsd_link_if_i.nco_synced === 1'b1)
      n_sync++;
    // Two edges after a sync pulse the accumulator is zero, so only the offset remains.
    if (sync_hist[1])
      check("phase after sync", nco_phase_a, {pa[3][15:0], 16'h0000});
    sync_hist = {sync_hist[0], rstn && dnsd_link_if_i.nco_synced === 1'b1};
    if (out_valid === 1'b1)
      n_valid++;
  end

  initial begin
    #(100 * 20000);
    miscompares++;
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    adc_sample = 12'h0;
    mixer_i = '0;
    mixer_q = '0;
    mixer_valid = 1'b1;
    overrange_flag_zero = 1'b0;
    overrange_flag_one = 1'b0;
    nco_sel_a = 2'h0;
    nco_sel_b = 2'h0;
    rng = 32'h968E;
    sync_hist = 2'h0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(8'h00, 32'h10);
    rd(8'h08, 32'h1);
    wr(8'hFC, 32'hFFFFFFFF);
    rd(8'hFC, 32'h0);
    for (int i = 0; i < 4; i++) begin
      pa[i] = xs();
      wr(8'h20 + 8'(4 * i), pa[i]);
      rd(8'h20 + 8'(4 * i), pa[i]);
    end
    // A half-word write must leave channel B's offset untouched.
    bus(1'b1, 8'h20, ~pa[0], 4'h3);
    pa[0] = {pa[0][31:16], ~pa[0][15:0]};
    rd(8'h20, pa[0]);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      nco_sel_a <= 2'(i);
      nco_sel_b <= 2'(i);
      idle(4);
      check("phase a", nco_phase_a, {pa[i][15:0], 16'h0});
      check("phase b", nco_phase_b, {pa[i][31:16], 16'h0});
    end
    fa = xs();
    wr(8'h4C, fa);
    wr(8'h6C, ~fa);
    rd(8'h4C, fa);
    rd(8'h6C, ~fa);
    idle(2);
    p0 = nco_phase_a;
    p1 = nco_phase_b;
    idle(1);
    check("accumulate a", nco_phase_a - p0, fa);
    check("accumulate b", nco_phase_b - p1, ~fa);
    @(posedge sys_clk);
    ce <= 1'b0;
    idle(2);
    p0 = nco_phase_a;
    idle(4);
    check("ce freeze", nco_phase_a, p0);
    @(posedge sys_clk);
    ce <= 1'b1;
    wr(8'h00, 32'h14);
    wr(8'h00, 32'h16);
    wr(8'h04, 32'h1);
    idle(12);
    check("dc sysref sync", 32'(n_sync), 32'h1);
    rd(8'h08, 32'h5);
    wr(8'h04, 32'h1);
    idle(12);
    check("second pulse", 32'(n_sync), 32'h1);
    wr(8'h08, 32'h4);
    rd(8'h08, 32'h1);
    wr(8'h00, 32'h34);
    wr(8'h00, 32'h36);
    idle(64);
    check("running sysref", 32'(n_sync), 32'h2);
    wr(8'h00, 32'h14);
    wr(8'h08, 32'h4);
    wr(8'h00, 32'h11);
    wr(8'h00, 32'h15);
    wr(8'h00, 32'h05);
    idle(8);
    rd(8'h08, 32'h2);
    wr(8'h00, 32'h15);
    idle(8);
    check("link sync", 32'(n_sync), 32'h3);
    rd(8'h08, 32'h5);
    wr(8'h08, 32'h4);
    wr(8'h00, 32'h19);
    wr(8'h00, 32'h1D);
    wr(8'h00, 32'h0D);
    idle(8);
    rd(8'h08, 32'h0);
    wr(8'h00, 32'h1D);
    idle(8);
    check("64b link sync", 32'(n_sync), 32'h4);
    wr(8'h00, 32'h14);
    wr(8'h00, 32'h04);
    idle(8);
    wr(8'h00, 32'h14);
    idle(8);
    check("sync refused", 32'(n_sync), 32'h4);
    for (int k = 0; k < 5; k++) begin
      void'(xs());
      @(posedge sys_clk);
      mixer_i <= {rng[13], rng[13:0]};
      mixer_q <= {rng[29], rng[29:16]};
      overrange_flag_zero <= rng[30];
      overrange_flag_one <= rng[31];
      adc_sample <= rng[11:0];
      wr(8'h00, 32'h14 | (32'(k) << 8));
      idle(200);
      n_valid = 0;
      idle(128);
      check("valid count", 32'(n_valid), (k == 0) ? 32'h80 : (32'h80 >> (k + 1)));
      check("complex", 32'(out_complex), 32'(k != 0));
      if (k == 0) begin
        check("real out", 32'(out_real), 32'(adc_sample));
      end else begin
        check("i data", 32'(out_i_word[15:1]), 32'(unsigned'(mixer_i)));
        check("q data", 32'(out_q_word[15:1]), 32'(unsigned'(mixer_q)));
        check("i flag", 32'(out_i_word[0]), 32'(overrange_flag_zero));
        check("q flag", 32'(out_q_word[0]), 32'(overrange_flag_one));
      end
    end
    complete_run();
  end
endmodule // ddc_nco_sync_decimation_tb
